// ==== logic/brake_mon_pkg.sv ====
/*
 Package for the per-axis braking ramp monitor channel.
 Assumes a single monitoring clock and unsigned speed magnitudes.
*/
package brake_mon_pkg;
	localparam int unsigned SPEED_W   = 16;             // Speed magnitude width
	localparam int unsigned SEL_W     = 8;              // Safety input width
	localparam int unsigned CAM_W     = 4;              // Output cam count
	localparam int unsigned WIN_W     = 16;             // Discrepancy window width
	localparam logic [SPEED_W-1:0] SPEED_ZERO = 16'h0000; // Limit value while idle
	localparam logic [WIN_W-1:0]   WIN_ZERO   = 16'h0000; // Discrepancy count reset

	// Configuration set, one per channel
	typedef struct packed {
		logic [SPEED_W-1:0] ramp_speed_tolerance;
		logic [SPEED_W-1:0] freeze_speed_threshold;
		logic [WIN_W-1:0]   discrepancy_cycles;
	} monitor_cfg_t;

	// Stop requests raised by the channel
	typedef struct packed {
		logic stop_a;
		logic stop_f;
	} stop_out_t;

	typedef enum logic [1:0] {
		RAMP_IDLE,
		RAMP_TRACK,
		RAMP_FROZEN
	} ramp_state_t;
endpackage

// ==== logic/safe_braking_ramp_monitor.sv ====
/*
 One monitoring channel of one axis: braking ramp monitor, safety
 input selection, safety output status and crosswise comparison.
 Assumes the twin channel delivers its inputs and results on the same
 monitoring clock; pins from outside pass a two-flop synchroniser.
*/
`timescale 1ns/1ps

// Function
// - Stop B or C arms monitor automatically
// - Violation raises stop A at once
// - Arming loads limit as speed plus tolerance
// - Each cycle compare, track limit downward
// - Below freeze threshold, hold threshold plus tolerance
// - Both channels instantiate, own parameter sets
// - Own safety inputs and outputs per channel
// - Inputs select functions, outputs report status
// - Selection independent of machine operating mode
// - Crosswise difference raises stop F
// - Logic zero is the fail-safe state
// - Fieldbus signals only via safe logic
// - Tolerate channel difference within window
module safe_braking_ramp_monitor
	import brake_mon_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               reset_n_i,
	// Stop requests and measured speed
	input  wire logic               stop_bc_req_i,
	input  wire logic [SPEED_W-1:0] actual_speed_i,
	// Own parameter set
	input  wire monitor_cfg_t       cfg_i,
	// Safety input signals from own hardware path and from safe logic
	input  wire logic [SEL_W-1:0]   safety_input_pin_i,
	input  wire logic [SEL_W-1:0]   safety_input_logic_i,
	input  wire logic               fieldbus_mode_i,
	input  wire logic [CAM_W-1:0]   cam_state_i,
	// Twin channel results
	input  wire logic [SEL_W-1:0]   twin_input_i,
	input  wire logic               twin_violation_i,
	// Outputs
	output logic [SEL_W-1:0]        safety_input_signal_o,
	output logic [SEL_W+CAM_W:0]    safety_output_signal_o,
	output logic                    violation_o,
	output stop_out_t               stop_o,
	output logic [SPEED_W-1:0]      speed_limit_o
);

	// Synchroniser for the pin path; first stage read only by second
	logic [SEL_W-1:0] pin_meta_q;
	logic [SEL_W-1:0] pin_sync_q;

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= safety_input_pin_i;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Saturating speed plus tolerance; wrap would lower the limit
	function automatic logic [SPEED_W-1:0] add_sat(input logic [SPEED_W-1:0] a,
	                                                 input logic [SPEED_W-1:0] b);
		logic [SPEED_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		add_sat = s[SPEED_W] ? {SPEED_W{1'b1}} : s[SPEED_W-1:0];
	endfunction

	// Ramp state
	ramp_state_t      state_q, state_d;
	logic [SPEED_W-1:0] limit_q, limit_d;
	logic             viol_q, viol_d;     // Sticky until stop request leaves
	logic [SEL_W-1:0] sel_q, sel_d;       // Active safety input selection
	logic [WIN_W-1:0] disc_q, disc_d;     // Discrepancy cycle counter
	logic             stop_f_q, stop_f_d;
	logic [SEL_W+CAM_W:0] sout_q, sout_d;

	// Next state of the braking ramp monitor
	always_comb begin
		state_d = state_q;
		limit_d = limit_q;
		viol_d  = viol_q;
		case (state_q)
			RAMP_IDLE: begin
				viol_d  = 1'b0;
				limit_d = SPEED_ZERO;
				if (stop_bc_req_i) begin
					state_d = RAMP_TRACK;
					limit_d = add_sat(actual_speed_i, cfg_i.ramp_speed_tolerance);
				end
			end
			RAMP_TRACK: begin
				if (!stop_bc_req_i) begin
					state_d = RAMP_IDLE;
				end else begin
					if (actual_speed_i > limit_q) begin
						viol_d = 1'b1;
					end
					if (actual_speed_i < cfg_i.freeze_speed_threshold) begin
						state_d = RAMP_FROZEN;
						limit_d = add_sat(cfg_i.freeze_speed_threshold,
						                  cfg_i.ramp_speed_tolerance);
					end else if (add_sat(actual_speed_i, cfg_i.ramp_speed_tolerance)
					             < limit_q) begin
						// Limit only follows downward so a rise is caught at once
						limit_d = add_sat(actual_speed_i, cfg_i.ramp_speed_tolerance);
					end
				end
			end
			RAMP_FROZEN: begin
				if (!stop_bc_req_i) begin
					state_d = RAMP_IDLE;
				end else if (actual_speed_i > limit_q) begin
					viol_d = 1'b1;
				end
			end
			default: begin
				state_d = RAMP_IDLE;
			end
		endcase
	end

	// Selection, crosswise comparison and status outputs
	always_comb begin
		// Fieldbus attached sensors reach the channel only via safe logic
		sel_d = fieldbus_mode_i ? safety_input_logic_i : pin_sync_q;
		// No operating-mode gate: selection applies in every mode
		disc_d   = disc_q;
		stop_f_d = stop_f_q; // Held until reset, a crosswise stop is latched
		if ((sel_q != twin_input_i) || (viol_q != twin_violation_i)) begin
			if (disc_q >= cfg_i.discrepancy_cycles) begin
				stop_f_d = 1'b1;
			end else begin
				disc_d = disc_q + 16'h0001;
			end
		end else begin
			disc_d = WIN_ZERO;
		end
		// Status: cams, selection echo and monitor-ok; any fault drops all to 0
		if (viol_q || stop_f_q) begin
			sout_d = '0;
		end else begin
			sout_d = {1'b1, cam_state_i, sel_q};
		end
	end

	// Register all state except the pin synchroniser
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q  <= RAMP_IDLE;
			limit_q  <= SPEED_ZERO;
			viol_q   <= 1'b0;
			sel_q    <= '0;
			disc_q   <= WIN_ZERO;
			stop_f_q <= 1'b0;
			sout_q   <= '0;
		end else begin
			state_q  <= state_d;
			limit_q  <= limit_d;
			viol_q   <= viol_d;
			sel_q    <= sel_d;
			disc_q   <= disc_d;
			stop_f_q <= stop_f_d;
			sout_q   <= sout_d;
		end
	end

	// Outputs straight from flip-flops
	assign safety_input_signal_o  = sel_q;
	assign safety_output_signal_o = sout_q;
	assign violation_o            = viol_q;
	assign stop_o.stop_a          = viol_q;
	assign stop_o.stop_f          = stop_f_q;
	assign speed_limit_o          = limit_q;

	// Arming loads speed plus tolerance
	arm_load_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_q == RAMP_IDLE && stop_bc_req_i) |=>
		(limit_q == add_sat($past(actual_speed_i), $past(cfg_i.ramp_speed_tolerance))))
		else $error("limit not loaded on arming");

	arm_auto_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_q == RAMP_IDLE && stop_bc_req_i) |=> (state_q == RAMP_TRACK))
		else $error("monitor did not arm");

	sequence track_over_s;
		(state_q != RAMP_IDLE) && stop_bc_req_i && (actual_speed_i > limit_q);
	endsequence

	breach_flag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		track_over_s |=> viol_q)
		else $error("breach not flagged");

	stop_a_out_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		track_over_s |=> stop_o.stop_a)
		else $error("stop A missing");

	limit_fall_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_q == RAMP_TRACK && state_d == RAMP_TRACK) |=> (limit_q <= $past(limit_q)))
		else $error("limit rose while tracking");

	freeze_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_q == RAMP_FROZEN) |-> (limit_q == add_sat(cfg_i.freeze_speed_threshold,
		                                                 cfg_i.ramp_speed_tolerance)))
		else $error("frozen limit wrong");

	idle_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(!stop_bc_req_i && state_q == RAMP_IDLE) |=> !viol_q)
		else $error("violation while idle");

	fail_safe_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(viol_q || stop_f_q) |=> (safety_output_signal_o == '0))
		else $error("outputs not fail-safe");

	cross_stop_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		((sel_q != twin_input_i) && disc_q >= cfg_i.discrepancy_cycles) |=> stop_o.stop_f)
		else $error("stop F missing");

	window_tol_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(!stop_f_q && disc_q < cfg_i.discrepancy_cycles) |=> !stop_o.stop_f)
		else $error("stop F inside window");

	bus_route_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		fieldbus_mode_i |=> (safety_input_signal_o == $past(safety_input_logic_i)))
		else $error("fieldbus input bypassed safe logic");

endmodule

// ==== bench/twin_channel_model.sv ====
/*
 Twin channel model: echoes selection and violation one cycle late,
 and inverts the selection on command. Assumes the shared clock/reset.
*/
`timescale 1ns/1ps
module twin_channel_model
	import brake_mon_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	// Own channel results and fault command
	input  wire logic [SEL_W-1:0] sel_i,
	input  wire logic             violation_i,
	input  wire logic             flip_i,
	// Results seen by the channel
	output logic [SEL_W-1:0]      twin_input_o,
	output logic                  twin_violation_o
);
	// Lag of one cycle models the slower twin path
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			twin_input_o     <= '0;
			twin_violation_o <= 1'b0;
		end else begin
			twin_input_o     <= sel_i ^ {SEL_W{flip_i}};
			twin_violation_o <= violation_i;
		end
	end
endmodule

// ==== bench/safe_braking_ramp_monitor_test.sv ====
/*
 Self-checking bench for one monitoring channel with a twin model.
 Assumes a 100 MHz clock; inputs change at rising edges.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("Error %s exp %h got %h", n, e, a); end end
module safe_braking_ramp_monitor_test;
	import brake_mon_pkg::*;
	logic               clk_sys_i = 1'b0; // Monitoring clock
	logic               reset_n_i = 1'b0; // Reset, active low
	logic               stop = 1'b0;      // Stop B/C pending
	logic [SPEED_W-1:0] speed = '0;       // Measured speed
	// Tolerance sized as acceleration times one cycle plus margin; short window
	monitor_cfg_t       cfg = '{16'h0020, 16'h0100, 16'h0004};
	logic [SEL_W-1:0]   pin = '0;         // Hardware inputs
	logic [SEL_W-1:0]   lgc = '0;         // Safe logic inputs
	logic               fb = 1'b1;        // Fieldbus routing
	logic [CAM_W-1:0]   cam = 4'h9;       // Cam states
	logic               flip = 1'b0;      // Twin fault command
	logic [SEL_W-1:0]   twin_sel, sel;
	logic               twin_viol, viol;
	logic [SEL_W+CAM_W:0] sout;
	stop_out_t          st;
	logic [SPEED_W-1:0] lim;
	int                 n_errors = 0, num_checks = 0, cycles = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	safe_braking_ramp_monitor i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.stop_bc_req_i(stop), .actual_speed_i(speed), .cfg_i(cfg),
		.safety_input_pin_i(pin), .safety_input_logic_i(lgc), .fieldbus_mode_i(fb),
		.cam_state_i(cam), .twin_input_i(twin_sel), .twin_violation_i(twin_viol),
		.safety_input_signal_o(sel), .safety_output_signal_o(sout),
		.violation_o(viol), .stop_o(st), .speed_limit_o(lim));
	twin_channel_model i_twin (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.sel_i(sel), .violation_i(viol), .flip_i(flip),
		.twin_input_o(twin_sel), .twin_violation_o(twin_viol));
	// Verdict and end of run, shared by the timeout
	task automatic results();
		if (n_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Waits n edges, then lets their updates land
	task automatic go(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// Three-cycle reset; outputs must stay cleared
	task automatic do_reset();
		@(posedge clk_sys_i) reset_n_i <= 1'b0;
		go(2);
		`CHK("reset", 32'h0, {sout, viol, lim, st})
		@(posedge clk_sys_i) reset_n_i <= 1'b1;
		go(2);
		`CHK("rearm", 3'b000, {st, viol})
	endtask
	// Idle: high speed must never flag without a stop
	task automatic t_idle();
		@(posedge clk_sys_i) speed <= 16'hffff;
		go(3);
		`CHK("idle", 17'h0, {viol, lim})
	endtask
	// Arm, track downward, equal speed, re-accelerate by one
	task automatic t_ramp();
		@(posedge clk_sys_i) begin stop <= 1'b1; speed <= 16'h1000; end
		go(1);
		`CHK("arm", 16'h1020, lim)
		@(posedge clk_sys_i) speed <= 16'h0f00;
		go(1);
		`CHK("track", 16'h0f20, lim)
		@(posedge clk_sys_i) speed <= 16'h0f20;
		go(1);
		`CHK("equal", 17'h0f20, {viol, lim})
		@(posedge clk_sys_i) speed <= 16'h0f21;
		go(1);
		`CHK("breach", 2'b11, {viol, st.stop_a})
		go(1);
		`CHK("failsafe", 13'h0, sout)
		@(posedge clk_sys_i) stop <= 1'b0;
		go(2);
		`CHK("release", 2'b00, {viol, st.stop_a})
	endtask
	// Below the freeze speed the limit holds at threshold plus tolerance
	task automatic t_freeze();
		@(posedge clk_sys_i) begin stop <= 1'b1; speed <= 16'h0150; end
		go(1);
		`CHK("arm2", 16'h0170, lim)
		@(posedge clk_sys_i) speed <= 16'h00ff;
		go(1);
		`CHK("freeze", 16'h0120, lim)
		@(posedge clk_sys_i) speed <= 16'h0010;
		go(2);
		`CHK("frozen", 17'h0120, {viol, lim})
		@(posedge clk_sys_i) stop <= 1'b0;
		go(2);
	endtask
	// Logic inputs take one edge, pins three; status carries cams
	task automatic t_select();
		@(posedge clk_sys_i) begin fb <= 1'b1; lgc <= 8'ha5; pin <= 8'h3c; end
		go(1);
		`CHK("logic sel", 8'ha5, sel)
		go(2);
		`CHK("status", {1'b1, 4'h9, 8'ha5}, sout)
		@(posedge clk_sys_i) fb <= 1'b0;
		go(3);
		`CHK("pin sel", 8'h3c, sel)
		go(4);
		`CHK("agree", 1'b0, st.stop_f)
	endtask
	// Short difference tolerated, long one raises a latched stop F
	task automatic t_cross();
		@(posedge clk_sys_i) flip <= 1'b1;
		go(3);
		@(posedge clk_sys_i) flip <= 1'b0;
		go(4);
		`CHK("short", 1'b0, st.stop_f)
		@(posedge clk_sys_i) flip <= 1'b1;
		go(10);
		@(posedge clk_sys_i) flip <= 1'b0;
		go(3);
		`CHK("long", 14'h0001, {sout, st.stop_f})
	endtask
	// Hang guard, well above the length of all tasks
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_idle();
		t_ramp();
		t_freeze();
		t_select();
		t_cross();
		do_reset();
		results();
	end
endmodule
